/* File: hw/rms_pkg.sv */
// rms_pkg: shared constants and carriers for the reset mode select block
// assumes an apb-attached register file and a core that issues bus requests
package rms_pkg;

    // operating modes, order follows the latched flag pair {special, mode_a}
    typedef enum logic [1:0]
    {
        RMS_SINGLE_CHIP,
        RMS_EXPANDED,
        RMS_BOOTSTRAP,
        RMS_TEST
    } rms_mode_type;

    // register byte offsets
    localparam logic [7:0] RMS_MODE_OFFSET   = 8'h00;
    localparam logic [7:0] RMS_STATUS_OFFSET = 8'h04;
    localparam logic [7:0] RMS_PRIV_OFFSET   = 8'h08;

    // field positions in the mode register
    localparam int RMS_MDA_BIT  = 0;
    localparam int RMS_SPECIAL_MODE_FLAG_BIT = 1;

    // status register fields
    localparam int RMS_LATCHED_LSB = 0;
    localparam int RMS_LOCK_BIT    = 2;

    // reset values
    localparam logic [7:0] RMS_PRIV_RESET = 8'h00;

    // width of the expanded address space, 64 kbytes
    localparam int RMS_ADDR_WIDTH = 16;
    localparam int RMS_DATA_WIDTH = 8;

    // one core bus request toward the external pins
    typedef struct packed
    {
        logic        valid;
        logic        write;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } rms_core_req_type;

    // state of the three external bus ports
    typedef struct packed
    {
        logic [7:0] port_b;
        logic [7:0] port_f;
        logic [7:0] port_c_out;
        logic       port_c_oe;
        logic       rw_n_write;
    } rms_ext_bus_type;

endpackage

/* File: hw/rms_mode_latch.sv */
// rms_mode_latch: captures the two mode pins once, right after reset release
// assumes mode pins are synchronous to pclk and stable around the release
`timescale 1ns/1ns
module rms_mode_latch
    import rms_pkg::*;
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         mode_select_a_pin,
    input  wire logic         mode_select_b_pin,
    output rms_pkg::rms_mode_type latched_mode,
    output logic              latched_valid
);

    // the capture happens at the first edge after release; async reset takes constants only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            latched_mode  <= RMS_SINGLE_CHIP;
            latched_valid <= 1'b0;
        end
        else if (!latched_valid)
        begin
            latched_valid <= 1'b1;
            // special flag is set when b is low, mode_a flag follows a
            latched_mode  <= rms_mode_type'({~mode_select_b_pin, mode_select_a_pin}); // [R3]
        end
    end

endmodule

/* File: hw/rms_mode_ctrl.sv */
// rms_mode_ctrl: operating mode selection and external bus port steering
// Behaviour
// [R1] mode pins sampled at reset choose among two normal and two special modes
// [R2] sampled pins set special-mode and mode-a flags in the mode register
// [R3] a/b 0/1 single, 1/1 expanded, 0/0 bootstrap, 1/0 test
// [R4] bootstrap mode fetches every vector from bootstrap rom
// [R5] test mode runs expanded bus and enables internal test functions
// [R6] privileged control bits writable only in special modes
// [R7] single chip gives address and data pins to ports
// [R8] single chip holds read/write output high
// [R9] expanded mode addresses a 64 kbyte space externally
// [R10] expanded space also covers internal ram, rom and registers
// [R11] expanded mode drives upper address on port b, lower on port f
// [R12] port c carries data; external memory drives only on reads
// [R13] read/write output marks each transfer direction
// [R14] software may switch modes by writing the two flags
// [R15] once special flag is written zero it stays zero until reset
// [R16] mode pins latched at reset release and ignored afterwards
// assumes an apb master on the register side and the cpu core on core_req
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ns
module rms_mode_ctrl
    import rms_pkg::*;
#(
    parameter int ADDR_WIDTH = RMS_ADDR_WIDTH
)
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 mode_select_a_pin,
    input  wire logic                 mode_select_b_pin,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  rms_pkg::rms_core_req_type core_req,
    input  wire logic                 core_req_internal,
    input  wire logic [7:0]           port_c_in,
    output logic [7:0]                core_rdata,
    output rms_pkg::rms_ext_bus_type  ext_bus,
    output logic                      ext_bus_enable,
    output logic                      boot_vector_select,
    output logic                      test_functions_enable,
    output logic [7:0]                privileged_bits,
    output rms_pkg::rms_mode_type     current_mode
);
    import rms_pkg::*;

    rms_mode_type latched_mode;
    logic         latched_valid;
    logic         latched_valid_d_reg;
    logic         special_mode_flag_reg;
    logic         mode_a_select_flag_reg;
    logic         special_mode_flag_locked_reg;
    logic [7:0]   priv_reg;
    logic         apb_access;
    logic         apb_write;
    logic         special_mode;
    logic         expanded_bus;
    logic         ext_cycle;

    // pins are caught once; later pin changes never reach the flags
    rms_mode_latch u_latch
    (
        .pclk              (pclk),
        .presetn           (presetn),
        .mode_select_a_pin (mode_select_a_pin),
        .mode_select_b_pin (mode_select_b_pin),
        .latched_mode      (latched_mode),
        .latched_valid     (latched_valid)
    ); // [R1] [R16]

    // zero-wait apb slave: access phase completes in its first cycle
    assign apb_access   = psel && penable;
    assign apb_write    = apb_access && pwrite;
    assign special_mode = special_mode_flag_reg;
    assign expanded_bus = mode_a_select_flag_reg; // test and expanded both have mode_a set [R5]
    assign ext_cycle    = expanded_bus && core_req.valid && !core_req_internal;

    // delayed capture flag so the flags load exactly once after the latch fills
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            latched_valid_d_reg <= 1'b0;
        else
            latched_valid_d_reg <= latched_valid;
    end

    // mode flags: loaded from pins once, then under software control
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            special_mode_flag_reg  <= 1'b0;
            mode_a_select_flag_reg <= 1'b0;
        end
        else if (latched_valid && !latched_valid_d_reg)
        begin
            special_mode_flag_reg  <= latched_mode[1]; // [R2]
            mode_a_select_flag_reg <= latched_mode[0]; // [R2]
        end
        else if (apb_write && paddr == RMS_MODE_OFFSET)
        begin
            // software may only clear the flag; a set would hand normal code the privileged bits
            special_mode_flag_reg  <= pwdata[RMS_SPECIAL_MODE_FLAG_BIT] && special_mode_flag_reg; // [R14] [R15]
            mode_a_select_flag_reg <= pwdata[RMS_MDA_BIT]; // [R14]
        end
    end

    // lock sets when software clears the special flag; only reset releases it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            special_mode_flag_locked_reg <= 1'b0;
        else if (latched_valid_d_reg && apb_write && paddr == RMS_MODE_OFFSET && !pwdata[RMS_SPECIAL_MODE_FLAG_BIT])
            special_mode_flag_locked_reg <= 1'b1; // [R15]
    end

    // privileged bits ignore writes outside special modes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            priv_reg <= RMS_PRIV_RESET;
        else if (apb_write && paddr == RMS_PRIV_OFFSET && special_mode)
            priv_reg <= pwdata[7:0]; // [R6]
    end

    // read mux and answer; unmapped addresses raise pslverr
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable)
            begin
                if (paddr == RMS_MODE_OFFSET)
                    prdata <= {30'h0000_0000, special_mode_flag_reg, mode_a_select_flag_reg};
                else if (paddr == RMS_STATUS_OFFSET)
                    prdata <= {29'h0000_0000, special_mode_flag_locked_reg, latched_mode};
                else if (paddr == RMS_PRIV_OFFSET)
                    prdata <= {24'h00_0000, priv_reg};
                else
                    pslverr <= 1'b1;
            end
        end
    end

    // external bus pins: ports in single chip, address/data bus when expanded
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_bus.port_b     <= 8'h00;
            ext_bus.port_f     <= 8'h00;
            ext_bus.port_c_out <= 8'h00;
            ext_bus.port_c_oe  <= 1'b0;
            ext_bus.rw_n_write <= 1'b1;
        end
        else if (!expanded_bus)
        begin
            // pins belong to port logic; read/write parks high for a clean mode change
            ext_bus.port_b     <= 8'h00; // [R7]
            ext_bus.port_f     <= 8'h00; // [R7]
            ext_bus.port_c_out <= 8'h00;
            ext_bus.port_c_oe  <= 1'b0;  // [R7]
            ext_bus.rw_n_write <= 1'b1;  // [R8]
        end
        else if (ext_cycle)
        begin
            ext_bus.port_b     <= core_req.addr[ADDR_WIDTH-1:ADDR_WIDTH-8]; // [R9] [R11]
            ext_bus.port_f     <= core_req.addr[7:0];  // [R11]
            ext_bus.port_c_out <= core_req.wdata;
            ext_bus.port_c_oe  <= core_req.write;      // [R12]
            ext_bus.rw_n_write <= !core_req.write;     // [R13]
        end
        else
        begin
            // idle: release data bus, show read so memory may not collide
            ext_bus.port_c_oe  <= 1'b0;  // [R12]
            ext_bus.rw_n_write <= 1'b1;  // [R13]
        end
    end

    // read data captured from port c one cycle after a read is issued
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            core_rdata <= 8'h00;
        else if (expanded_bus && ext_bus.rw_n_write && !ext_bus.port_c_oe)
            core_rdata <= port_c_in; // [R12]
    end

    // mode-derived status outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_bus_enable        <= 1'b0;
            boot_vector_select    <= 1'b0;
            test_functions_enable <= 1'b0;
            privileged_bits       <= RMS_PRIV_RESET;
            current_mode          <= RMS_SINGLE_CHIP;
        end
        else
        begin
            // internal ram, rom and registers stay in the map; the core flags them internal
            ext_bus_enable        <= expanded_bus; // [R10]
            boot_vector_select    <= special_mode && !mode_a_select_flag_reg; // [R4]
            test_functions_enable <= special_mode && mode_a_select_flag_reg;  // [R5]
            privileged_bits       <= priv_reg;
            current_mode          <= rms_mode_type'({special_mode_flag_reg, mode_a_select_flag_reg});
        end
    end

    // flags follow the pins right after the one-time load
    property p_flags_from_pins;
        @(posedge pclk) disable iff (!presetn)
        (latched_valid && !latched_valid_d_reg) |=>
            ({special_mode_flag_reg, mode_a_select_flag_reg} == $past(latched_mode));
    endproperty
    a_flags_from_pins: assert property (p_flags_from_pins) else $error("flags differ from latched pins"); // [R2]

    property p_lock_holds;
        @(posedge pclk) disable iff (!presetn)
        special_mode_flag_locked_reg |-> !special_mode_flag_reg;
    endproperty
    a_lock_holds: assert property (p_lock_holds) else $error("special flag set after lock"); // [R15]

    property p_priv_guard;
        @(posedge pclk) disable iff (!presetn)
        !special_mode |=> (priv_reg == $past(priv_reg));
    endproperty
    a_priv_guard: assert property (p_priv_guard) else $error("privileged bits changed in normal mode"); // [R6]

    property p_single_rw_high;
        @(posedge pclk) disable iff (!presetn)
        (!expanded_bus) |=> (ext_bus.rw_n_write && !ext_bus.port_c_oe);
    endproperty
    a_single_rw_high: assert property (p_single_rw_high) else $error("read/write low in single chip"); // [R8]

    property p_addr_split;
        @(posedge pclk) disable iff (!presetn)
        ext_cycle |=> ({ext_bus.port_b, ext_bus.port_f} == $past(core_req.addr));
    endproperty
    a_addr_split: assert property (p_addr_split) else $error("address not on ports b and f"); // [R11]

    property p_drive_on_write;
        @(posedge pclk) disable iff (!presetn)
        ext_bus.port_c_oe |-> !ext_bus.rw_n_write;
    endproperty
    a_drive_on_write: assert property (p_drive_on_write) else $error("data driven during read"); // [R13]

    property p_boot_vectors;
        @(posedge pclk) disable iff (!presetn)
        (special_mode && !mode_a_select_flag_reg) |=> boot_vector_select;
    endproperty
    a_boot_vectors: assert property (p_boot_vectors) else $error("bootstrap vectors not selected"); // [R4]

    property p_test_funcs;
        @(posedge pclk) disable iff (!presetn)
        (special_mode && mode_a_select_flag_reg) |=> (test_functions_enable && ext_bus_enable);
    endproperty
    a_test_funcs: assert property (p_test_funcs) else $error("test mode missing bus or test enable"); // [R5]

    property p_pins_ignored;
        @(posedge pclk) disable iff (!presetn)
        latched_valid_d_reg |=> $stable(latched_mode);
    endproperty
    a_pins_ignored: assert property (p_pins_ignored) else $error("latched mode changed after reset"); // [R16]

    // a cleared special flag stays cleared until the next reset
    property p_special_mode_flag_clear_only;
        @(posedge pclk) disable iff (!presetn)
        (latched_valid_d_reg && !special_mode_flag_reg) |=> !special_mode_flag_reg;
    endproperty
    a_special_mode_flag_clear_only: assert property (p_special_mode_flag_clear_only) else $error("special flag set again"); // [R15]

    // single chip leaves the address ports to port logic
    property p_single_ports_idle;
        @(posedge pclk) disable iff (!presetn)
        (!expanded_bus) |=> (ext_bus.port_b == 8'h00 && ext_bus.port_f == 8'h00);
    endproperty
    a_single_ports_idle: assert property (p_single_ports_idle) else $error("address ports busy in single chip"); // [R7]

    // internal hits never start an external cycle
    property p_internal_no_drive;
        @(posedge pclk) disable iff (!presetn)
        (expanded_bus && core_req.valid && core_req_internal) |=>
            (!ext_bus.port_c_oe && ext_bus.rw_n_write);
    endproperty
    a_internal_no_drive: assert property (p_internal_no_drive) else $error("external cycle for internal hit"); // [R10]

    // a write puts its data on port c
    property p_write_drives;
        @(posedge pclk) disable iff (!presetn)
        (ext_cycle && core_req.write) |=>
            (ext_bus.port_c_oe && ext_bus.port_c_out == $past(core_req.wdata));
    endproperty
    a_write_drives: assert property (p_write_drives) else $error("write data not driven"); // [R12]

    // a read leaves port c to the memory and shows read
    property p_read_releases;
        @(posedge pclk) disable iff (!presetn)
        (ext_cycle && !core_req.write) |=> (!ext_bus.port_c_oe && ext_bus.rw_n_write);
    endproperty
    a_read_releases: assert property (p_read_releases) else $error("data bus held during read"); // [R13]

    // reported mode follows the two flags one edge later
    property p_mode_report;
        @(posedge pclk) disable iff (!presetn)
        latched_valid_d_reg |=>
            (current_mode == $past({special_mode_flag_reg, mode_a_select_flag_reg}));
    endproperty
    a_mode_report: assert property (p_mode_report) else $error("reported mode differs from flags"); // [R2]

    // external bus enable tracks the mode_a flag
    property p_ext_enable;
        @(posedge pclk) disable iff (!presetn)
        latched_valid_d_reg |=> (ext_bus_enable == $past(mode_a_select_flag_reg));
    endproperty
    a_ext_enable: assert property (p_ext_enable) else $error("bus enable differs from mode flag"); // [R9]

    // the privileged copy on the output follows the register
    property p_priv_copy;
        @(posedge pclk) disable iff (!presetn)
        latched_valid_d_reg |=> (privileged_bits == $past(priv_reg));
    endproperty
    a_priv_copy: assert property (p_priv_copy) else $error("privileged output differs"); // [R6]

    // normal modes never show bootstrap vectors or test functions
    property p_normal_no_special;
        @(posedge pclk) disable iff (!presetn)
        (!special_mode) |=> (!boot_vector_select && !test_functions_enable);
    endproperty
    a_normal_no_special: assert property (p_normal_no_special) else $error("special output in normal mode"); // [R4]

    // zero wait states: every setup is answered in the first access cycle
    property p_pready_answer;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready;
    endproperty
    a_pready_answer: assert property (p_pready_answer) else $error("no ready in first access cycle");

endmodule

/* File: dv/rms_ext_mem.sv */
// rms_ext_mem: external memory sitting on the expanded bus, 256 bytes
// assumes ext_bus and ext_bus_enable from the mode controller
`timescale 1ns/1ns
module rms_ext_mem
    import rms_pkg::*;
(
    input  wire logic                pclk,
    input  rms_pkg::rms_ext_bus_type ext_bus,
    input  wire logic                bus_on,
    output logic [7:0]               port_c_in
);
    import rms_pkg::*;
    logic [7:0] mem [256];
    logic [7:0] last;
    // store while the device drives port c for a write
    always_ff @(posedge pclk)
    begin
        if (bus_on && !ext_bus.rw_n_write && ext_bus.port_c_oe)
            mem[ext_bus.port_f] <= ext_bus.port_c_out;
        last <= port_c_in;
    end
    // drive only on reads; otherwise a changing pattern so stale data never matches
    assign port_c_in = (bus_on && ext_bus.rw_n_write && !ext_bus.port_c_oe) ? mem[ext_bus.port_f] : ~last;
endmodule

/* File: dv/rms_mode_ctrl_tb_top.sv */
// rms_mode_ctrl_tb_top: self-checking bench for the mode controller
// assumes rms_pkg, rms_mode_ctrl and the rms_ext_mem partner model
`timescale 1ns/1ns
module rms_mode_ctrl_tb_top;
    import rms_pkg::*;
    logic pclk, presetn, mode_select_a_pin, mode_select_b_pin;
    logic psel, penable, pwrite, pready, pslverr, core_req_internal;
    logic ext_bus_enable, boot_vector_select, test_functions_enable;
    logic [7:0] paddr, port_c_in, core_rdata, privileged_bits;
    logic [31:0] pwdata, prdata;
    rms_core_req_type core_req;
    rms_ext_bus_type ext_bus;
    rms_mode_type current_mode;
    logic [32:0] exp_q [$];
    int err_count, checks_done;
    logic [15:0] a;
    logic [7:0] d;

    rms_mode_ctrl DUT (.pclk(pclk), .presetn(presetn), .mode_select_a_pin(mode_select_a_pin),
        .mode_select_b_pin(mode_select_b_pin), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .core_req(core_req), .core_req_internal(core_req_internal), .port_c_in(port_c_in),
        .core_rdata(core_rdata), .ext_bus(ext_bus), .ext_bus_enable(ext_bus_enable),
        .boot_vector_select(boot_vector_select), .test_functions_enable(test_functions_enable),
        .privileged_bits(privileged_bits), .current_mode(current_mode));
    rms_ext_mem mem (.pclk(pclk), .ext_bus(ext_bus), .bus_on(ext_bus_enable), .port_c_in(port_c_in));

    task test_done;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task chk(input logic [32:0] got, input logic [32:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
            err_count++;
        end
    endtask

    // apb master: hold request until pready seen, notes read expectation
    task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd, input logic [32:0] e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        if (!w)
            exp_q.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            err_count++;
            test_done();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // one core request held for a single edge, then idle
    task core(input logic w, input logic [15:0] ca, input logic [7:0] cd, input logic in);
        @(posedge pclk);
        core_req <= '{1'b1, w, ca, cd};
        core_req_internal <= in;
        @(posedge pclk);
        core_req.valid <= 1'b0;
        core_req_internal <= 1'b0;
        #1;
    endtask

    // strap pins per mode {special, mode_a}: a = mode_a, b = not special
    task reset_to(input logic [1:0] m);
        @(posedge pclk);
        presetn <= 1'b0;
        mode_select_a_pin <= m[0];
        mode_select_b_pin <= ~m[1];
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        mode_select_a_pin <= ~m[0];
        mode_select_b_pin <= m[1];
        repeat (2) @(posedge pclk);
        #1;
    endtask

    // monitor: each read answer takes the oldest note
    always @(posedge pclk)
        if (psel && penable && pready === 1'b1 && !pwrite)
            chk({pslverr, prdata}, exp_q.pop_front());

    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    initial
    begin
        repeat (5000) @(posedge pclk);
        err_count++;
        test_done();
    end

    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, core_req_internal} = '0;
        {mode_select_a_pin, mode_select_b_pin, core_req} = '0;
        err_count = 0;
        checks_done = 0;
        void'($urandom(32'h6194));
        for (int m = 0; m < 4; m++)
        begin
            reset_to(m[1:0]);
            chk(current_mode, 33'(m));
            chk(ext_bus_enable, m[0]);
            chk(boot_vector_select, m == 2);
            chk(test_functions_enable, m == 3);
            apb(1'b0, RMS_MODE_OFFSET, 32'h0, 33'(m));
            apb(1'b0, RMS_STATUS_OFFSET, 32'h0, 33'(m));
            d = 8'($urandom());
            a = 16'($urandom());
            apb(1'b1, RMS_PRIV_OFFSET, {24'h0, d}, 33'h0);
            apb(1'b0, RMS_PRIV_OFFSET, 32'h0, m[1] ? {25'h0, d} : 33'h0);
            core(1'b1, a, d, 1'b0);
            chk(ext_bus, m[0] ? {a, d, 2'b10} : 33'h1);
            chk(privileged_bits, m[1] ? d : 8'h00);
            core(1'b0, a, 8'h00, 1'b0);
            chk({ext_bus.port_c_oe, ext_bus.rw_n_write}, 33'h1);
            if (m[0])
            begin
                chk({ext_bus.port_b, ext_bus.port_f}, a);
                @(posedge pclk);
                #1;
                chk(core_rdata, d);
            end
            core(1'b1, ~a, ~d, 1'b1);
            chk({ext_bus.port_c_oe, ext_bus.rw_n_write}, 33'h1);
        end
        // still in test mode: leave the special mode by software
        apb(1'b1, RMS_MODE_OFFSET, 32'h1, 33'h0);
        repeat (3) @(posedge pclk);
        chk(current_mode, 33'h1);
        apb(1'b0, RMS_STATUS_OFFSET, 32'h0, 33'h7);
        apb(1'b1, RMS_MODE_OFFSET, 32'h3, 33'h0);
        apb(1'b0, RMS_MODE_OFFSET, 32'h0, 33'h1);
        apb(1'b1, RMS_PRIV_OFFSET, {24'h0, ~d}, 33'h0);
        apb(1'b0, RMS_PRIV_OFFSET, 32'h0, {25'h0, d});
        chk(privileged_bits, d);
        apb(1'b1, RMS_STATUS_OFFSET, 32'h0, 33'h0);
        apb(1'b0, RMS_STATUS_OFFSET, 32'h0, 33'h7);
        apb(1'b0, 8'h0c, 32'h0, {1'b1, 32'h0});
        apb(1'b1, RMS_MODE_OFFSET, 32'h0, 33'h0);
        repeat (3) @(posedge pclk);
        chk(current_mode, 33'h0);
        core(1'b1, a, d, 1'b0);
        chk(ext_bus, 33'h1);
        repeat (3) @(posedge pclk);
        test_done();
    end
endmodule
